//--- hdl/irq_mux_pkg.sv
// Package: vectors, priorities and carriers for the interrupt source mux
package irq_mux_pkg;
    localparam int NUM_VEC = 17;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_LOWEST = 16'hFFDC;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    localparam logic [4:0] PRIO_TRAP = 5'h00;
    localparam logic [4:0] PRIO_EXT_PIN = 5'h01;
    localparam logic [4:0] PRIO_PLL = 5'h02;
    localparam logic [4:0] PRIO_T1_CH0 = 5'h03;
    localparam logic [4:0] PRIO_T1_CH1 = 5'h04;
    localparam logic [4:0] PRIO_T1_WRAP = 5'h05;
    localparam logic [4:0] PRIO_T2_CH0 = 5'h06;
    localparam logic [4:0] PRIO_T2_CH1 = 5'h07;
    localparam logic [4:0] PRIO_T2_WRAP = 5'h08;
    localparam logic [4:0] PRIO_SPI_RX = 5'h09;
    localparam logic [4:0] PRIO_SPI_TX = 5'h0A;
    localparam logic [4:0] PRIO_SCI_ERR = 5'h0B;
    localparam logic [4:0] PRIO_SCI_RX = 5'h0C;
    localparam logic [4:0] PRIO_SCI_TX = 5'h0D;
    localparam logic [4:0] PRIO_KBD = 5'h0E;
    localparam logic [4:0] PRIO_ADC = 5'h0F;
    localparam logic [4:0] PRIO_TIMEBASE = 5'h10;
    localparam int KBD_PINS = 8;
    localparam logic [3:0] IDLE_BITS_MIN = 4'hA;

    // One timer's event inputs and enables
    typedef struct packed {
        logic wrap_event;
        logic [1:0] channel_event;
        logic wrap_enable;
        logic [1:0] channel_event_enable;
    } timer_src_s;

    // Winning request handed to the CPU core
    typedef struct packed {
        logic valid;
        logic [4:0] prio;
        logic [15:0] vector;
        logic is_trap;
    } cpu_req_s;
endpackage : irq_mux_pkg

//--- hdl/cpu_interrupt_source_mux.sv
// Interrupt source flags, gating, fixed priority and vector selection
module cpu_interrupt_source_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // External pins, asynchronous
    input wire logic ext_request_pin,
    input wire logic [irq_mux_pkg::KBD_PINS-1:0] kbd_pin,
    input wire logic slave_select_input,
    input wire logic rx_line,
    // Pin masks (high blocks the request); kbd_pin_enable is per pin, high lets that pin request
    input wire logic ext_pin_request_mask,
    input wire logic kbd_pin_mask,
    input wire logic [irq_mux_pkg::KBD_PINS-1:0] kbd_pin_enable,
    // Clock generator
    input wire logic pll_lock,
    input wire logic pll_sync_change_enable,
    // Timers
    input wire irq_mux_pkg::timer_src_s timer1,
    input wire irq_mux_pkg::timer_src_s timer2,
    // SPI events and enables
    input wire logic spi_rx_load,
    input wire logic spi_tx_load,
    input wire logic spi_rx_read,
    input wire logic spi_transfer_active,
    input wire logic spi_master_mode,
    input wire logic spi_mode_fault_check_enable,
    input wire logic spi_rx_full_enable,
    input wire logic spi_tx_empty_enable,
    input wire logic spi_fault_irq_enable,
    // SCI events and enables
    input wire logic sci_tx_load,
    input wire logic sci_tx_shift_empty,
    input wire logic sci_tx_data_empty,
    input wire logic sci_break_or_idle_gen,
    input wire logic sci_rx_load,
    input wire logic sci_rx_read,
    input wire logic sci_rx_bit_tick,
    input wire logic sci_long_char,
    input wire logic sci_stop_bit_zero,
    input wire logic sci_noise_seen,
    input wire logic sci_parity_mismatch,
    input wire logic sci_tx_empty_enable,
    input wire logic tx_done_enable,
    input wire logic sci_rx_full_enable,
    input wire logic line_quiet_enable,
    input wire logic rx_overrun_enable,
    input wire logic line_noise_enable,
    input wire logic stop_bit_bad_enable,
    input wire logic parity_bad_enable,
    // ADC and timebase, already-gated requests
    input wire logic adc_request,
    input wire logic timebase_request,
    // Software flag clears, one pulse per flag, bit order as flag_view
    input wire logic [20:0] flag_clear,
    // CPU core handshake
    input wire logic instr_boundary,
    input wire logic software_trap_instr,
    input wire logic break_hit,
    input wire logic [15:0] pc_now,
    input wire logic mask_set_by_sw,
    input wire logic mask_clear_by_sw,
    // Outputs to the CPU core
    output irq_mux_pkg::cpu_req_s cpu_req,
    output logic [15:0] stacked_pc,
    output logic take_pulse,
    output logic global_mask,
    output logic [irq_mux_pkg::NUM_VEC-1:1] pending_view,
    output logic [20:0] flag_view
);
    // Pin synchronisers; first stage feeds only the second
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [irq_mux_pkg::KBD_PINS-1:0] kbd_s1_reg;
    logic [irq_mux_pkg::KBD_PINS-1:0] kbd_s2_reg;
    logic ss_prev_reg;
    logic pll_prev_reg;
    logic pll_primed_reg;
    logic [3:0] ones_count_reg;
    logic quiet_armed_reg;

    // Reset to the idle high level of the pins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1_reg <= 3'h7;
            pin_s2_reg <= 3'h7;
        end else begin
            pin_s1_reg <= {rx_line, slave_select_input, ext_request_pin};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            kbd_s1_reg <= '1;
            kbd_s2_reg <= '1;
        end else begin
            kbd_s1_reg <= kbd_pin;
            kbd_s2_reg <= kbd_s1_reg;
        end
    end

    // Edge history; a lock already held at reset release is no change
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ss_prev_reg <= 1'b1;
            pll_prev_reg <= 1'b0;
            pll_primed_reg <= 1'b0;
        end else begin
            ss_prev_reg <= pin_s2_reg[1];
            pll_prev_reg <= pll_lock;
            pll_primed_reg <= 1'b1;
        end
    end

    logic ss_now;
    logic ss_rise;
    logic ss_fall;
    assign ss_now = pin_s2_reg[1];
    assign ss_rise = ss_now && !ss_prev_reg;
    assign ss_fall = !ss_now && ss_prev_reg;

    // Idle line counter; counts received ones at bit ticks
    logic [3:0] idle_target;
    logic quiet_event;
    assign idle_target = sci_long_char ? irq_mux_pkg::IDLE_BITS_MIN + 4'h1
                                       : irq_mux_pkg::IDLE_BITS_MIN;
    assign quiet_event = sci_rx_bit_tick && pin_s2_reg[2] && quiet_armed_reg
                         && (ones_count_reg + 4'h1 == idle_target);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ones_count_reg <= 4'h0;
            quiet_armed_reg <= 1'b1;
        end else if (sci_rx_bit_tick) begin
            if (!pin_s2_reg[2]) begin
                ones_count_reg <= 4'h0;
                quiet_armed_reg <= 1'b1;
            end else if (quiet_event) begin
                ones_count_reg <= 4'h0;
                quiet_armed_reg <= 1'b0;
            end else if (quiet_armed_reg) begin
                ones_count_reg <= ones_count_reg + 4'h1;
            end
        end
    end

    // Unread data trackers; full flags are cleared apart from the data read
    logic spi_unread_reg;
    logic sci_unread_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            spi_unread_reg <= 1'b0;
            sci_unread_reg <= 1'b0;
        end else begin
            spi_unread_reg <= spi_rx_load || (spi_unread_reg && !spi_rx_read);
            sci_unread_reg <= sci_rx_load || (sci_unread_reg && !sci_rx_read);
        end
    end

    // Event sources for the 21 sticky flags
    logic [20:0] flag_set;
    logic [20:0] flag_reg;
    logic [irq_mux_pkg::KBD_PINS-1:0] kbd_low;
    assign kbd_low = ~kbd_s2_reg & kbd_pin_enable;

    always_comb begin
        flag_set = '0;
        flag_set[0] = !pin_s2_reg[0];
        flag_set[1] = pll_primed_reg && (pll_lock != pll_prev_reg);
        flag_set[2] = timer1.channel_event[0];
        flag_set[3] = timer1.channel_event[1];
        flag_set[4] = timer1.wrap_event;
        flag_set[5] = timer2.channel_event[0];
        flag_set[6] = timer2.channel_event[1];
        flag_set[7] = timer2.wrap_event;
        flag_set[8] = spi_rx_load;
        flag_set[9] = spi_rx_load && spi_unread_reg && !spi_rx_read;
        flag_set[10] = spi_mode_fault_check_enable &&
            (spi_master_mode ? ss_fall : (ss_rise && spi_transfer_active));
        flag_set[11] = spi_tx_load;
        flag_set[12] = sci_rx_load && sci_unread_reg && !sci_rx_read;
        flag_set[13] = sci_noise_seen;
        flag_set[14] = sci_stop_bit_zero;
        flag_set[15] = sci_parity_mismatch;
        flag_set[16] = sci_rx_load;
        flag_set[17] = quiet_event;
        flag_set[18] = sci_tx_load;
        flag_set[19] = sci_tx_shift_empty && sci_tx_data_empty
                       && !sci_break_or_idle_gen;
        flag_set[20] = |kbd_low;
    end

    // Sticky flags; a set in the clear cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < 21; gi++) begin : g_flag
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    flag_reg[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flag_reg[gi] <= 1'b1;
                end else if (flag_clear[gi]) begin
                    flag_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Per-vector gated requests, index = priority
    logic [irq_mux_pkg::NUM_VEC-1:1] vec_req;
    always_comb begin
        vec_req = '0;
        vec_req[irq_mux_pkg::PRIO_EXT_PIN] = flag_reg[0] && !ext_pin_request_mask;
        vec_req[irq_mux_pkg::PRIO_PLL] = flag_reg[1] && pll_sync_change_enable;
        vec_req[irq_mux_pkg::PRIO_T1_CH0] = flag_reg[2] && timer1.channel_event_enable[0];
        vec_req[irq_mux_pkg::PRIO_T1_CH1] = flag_reg[3] && timer1.channel_event_enable[1];
        vec_req[irq_mux_pkg::PRIO_T1_WRAP] = flag_reg[4] && timer1.wrap_enable;
        vec_req[irq_mux_pkg::PRIO_T2_CH0] = flag_reg[5] && timer2.channel_event_enable[0];
        vec_req[irq_mux_pkg::PRIO_T2_CH1] = flag_reg[6] && timer2.channel_event_enable[1];
        vec_req[irq_mux_pkg::PRIO_T2_WRAP] = flag_reg[7] && timer2.wrap_enable;
        vec_req[irq_mux_pkg::PRIO_SPI_RX] = (flag_reg[8] && spi_rx_full_enable)
            || ((flag_reg[9] || flag_reg[10]) && spi_fault_irq_enable);
        vec_req[irq_mux_pkg::PRIO_SPI_TX] = flag_reg[11] && spi_tx_empty_enable;
        vec_req[irq_mux_pkg::PRIO_SCI_ERR] = (flag_reg[12] && rx_overrun_enable)
            || (flag_reg[13] && line_noise_enable)
            || (flag_reg[14] && stop_bit_bad_enable)
            || (flag_reg[15] && parity_bad_enable);
        vec_req[irq_mux_pkg::PRIO_SCI_RX] = (flag_reg[16] && sci_rx_full_enable)
            || (flag_reg[17] && line_quiet_enable);
        vec_req[irq_mux_pkg::PRIO_SCI_TX] = (flag_reg[18] && sci_tx_empty_enable)
            || (flag_reg[19] && tx_done_enable);
        vec_req[irq_mux_pkg::PRIO_KBD] = flag_reg[20] && !kbd_pin_mask;
        vec_req[irq_mux_pkg::PRIO_ADC] = adc_request;
        vec_req[irq_mux_pkg::PRIO_TIMEBASE] = timebase_request;
    end

    // Lowest index wins; scan from bottom so the last hit is highest priority
    logic [4:0] win_prio;
    logic win_any;
    always_comb begin
        win_prio = 5'h00;
        win_any = 1'b0;
        for (int i = irq_mux_pkg::NUM_VEC - 1; i >= 1; i--) begin
            if (vec_req[i]) begin
                win_prio = 5'(i);
                win_any = 1'b1;
            end
        end
    end

    // Trap request, from instruction or break point
    logic trap_req;
    assign trap_req = software_trap_instr || break_hit;

    // Mask is the registered bit, so a clear pulse opens the gate a cycle later
    logic hw_take;
    assign hw_take = instr_boundary && win_any && !global_mask;

    logic [15:0] win_vector;
    // Reset owns the top pair, so group n sits n pairs below the trap pair
    assign win_vector = irq_mux_pkg::VEC_TRAP - 16'({win_prio, 1'b0});

    // Request to the CPU, one pulse per taken interrupt
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cpu_req <= '0;
            stacked_pc <= 16'h0000;
            take_pulse <= 1'b0;
        end else if (trap_req) begin
            cpu_req.valid <= 1'b1;
            cpu_req.prio <= irq_mux_pkg::PRIO_TRAP;
            cpu_req.vector <= irq_mux_pkg::VEC_TRAP;
            cpu_req.is_trap <= 1'b1;
            stacked_pc <= pc_now;
            take_pulse <= 1'b1;
        end else if (hw_take) begin
            cpu_req.valid <= 1'b1;
            cpu_req.prio <= win_prio;
            cpu_req.vector <= win_vector;
            cpu_req.is_trap <= 1'b0;
            stacked_pc <= pc_now - 16'h0001;
            take_pulse <= 1'b1;
        end else begin
            cpu_req.valid <= 1'b0;
            take_pulse <= 1'b0;
        end
    end

    // Global mask; set on reset and on every take
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            global_mask <= 1'b1;
        end else if (trap_req || hw_take || mask_set_by_sw) begin
            global_mask <= 1'b1;
        end else if (mask_clear_by_sw) begin
            global_mask <= 1'b0;
        end
    end

    // Visible pending bits and flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_view <= '0;
        end else begin
            pending_view <= vec_req;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_view <= '0;
        end else begin
            flag_view <= flag_reg;
        end
    end
endmodule : cpu_interrupt_source_mux

//--- dv/irq_mux_monitor.sv
// Checker: port-level properties of the interrupt source mux
module irq_mux_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched inputs
    input wire logic software_trap_instr,
    input wire logic break_hit,
    input wire logic [15:0] pc_now,
    input wire logic pll_lock,
    input wire logic spi_rx_load,
    input wire irq_mux_pkg::timer_src_s timer1,
    // Watched outputs
    input wire irq_mux_pkg::cpu_req_s cpu_req,
    input wire logic [15:0] stacked_pc,
    input wire logic take_pulse,
    input wire logic global_mask,
    input wire logic [irq_mux_pkg::NUM_VEC-1:1] pending_view,
    input wire logic [20:0] flag_view
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_trap_vector: assert property ((software_trap_instr || break_hit) |=>
        cpu_req.valid && cpu_req.is_trap && cpu_req.vector == 16'hFFFC && cpu_req.prio == 5'h00)
        else $error("trap not taken on its vector");
    a_trap_stack: assert property ((software_trap_instr || break_hit) |=>
        stacked_pc == $past(pc_now)) else $error("trap stacked wrong address");
    a_hw_stack: assert property (cpu_req.valid && !cpu_req.is_trap |->
        stacked_pc == $past(pc_now) - 16'h0001) else $error("hw take stacked wrong address");
    a_mask_blocks: assert property (global_mask && !software_trap_instr && !break_hit |=>
        !take_pulse) else $error("take while masked");
    a_take_masks: assert property (take_pulse |-> global_mask && cpu_req.valid)
        else $error("take without mask set");
    a_vec_pair: assert property (cpu_req.valid && !cpu_req.is_trap |-> cpu_req.prio != 5'h00 &&
        cpu_req.vector == 16'hFFFC - {10'h000, cpu_req.prio, 1'b0}) else $error("vector mismatch");
    a_top_prio: assert property (cpu_req.valid && !cpu_req.is_trap |->
        pending_view[cpu_req.prio] && (pending_view & ~({16{1'b1}} << (cpu_req.prio - 5'h01))) == 16'h0000)
        else $error("lower priority won");
    a_pll_flag: assert property ($changed(pll_lock) |-> ##[1:2] flag_view[1])
        else $error("lock change not flagged");
    a_spi_rx_flag: assert property (spi_rx_load |-> ##2 flag_view[8])
        else $error("spi receive flag missing");
    a_wrap_flag: assert property (timer1.wrap_event |-> ##2 flag_view[4])
        else $error("timer wrap flag missing");
    c_trap: cover property (take_pulse && cpu_req.is_trap);
    c_hw: cover property (take_pulse && !cpu_req.is_trap);
    c_wait: cover property (global_mask && pending_view != 16'h0000);
endmodule : irq_mux_monitor

bind cpu_interrupt_source_mux irq_mux_monitor mon (.clk, .reset, .software_trap_instr, .break_hit,
    .pc_now, .pll_lock, .spi_rx_load, .timer1, .cpu_req, .stacked_pc, .take_pulse, .global_mask,
    .pending_view, .flag_view);

//--- dv/cpu_seq_model.sv
// Partner model: CPU core sequencer offering instruction boundaries
module cpu_seq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pacing and feedback
    input wire logic slow,
    input wire logic take_pulse,
    // To the mux; take_count goes to the testbench
    output logic instr_boundary,
    output logic [7:0] take_count
);
    logic [1:0] phase_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_reg <= 2'h0;
            take_count <= 8'h00;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            take_count <= take_count + {7'h00, take_pulse};
        end
    end
    // Long instructions offer a boundary only every fourth cycle
    assign instr_boundary = !slow || phase_reg == 2'h0;
endmodule : cpu_seq_model

//--- dv/cpu_interrupt_source_mux_tb_top.sv
// Testbench: flags, gating, priority, vectors and stacking of the mux
module cpu_interrupt_source_mux_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = '0, reset = '1, slow = '0, ext_request_pin = '1, slave_select_input = '1;
    logic rx_line = '1, ext_pin_request_mask = '0, kbd_pin_mask = '0, pll_lock = '0;
    logic [7:0] kbd_pin = 8'hFF, kbd_pin_enable = 8'hFF, take_count, t0;
    logic [12:0] p = '0;
    logic [2:0] ten = 3'h7;
    logic pll_sync_change_enable = '1, spi_rx_read = '0, spi_transfer_active = '0;
    logic spi_master_mode = '0, spi_mode_fault_check_enable = '1, spi_rx_full_enable = '1;
    logic spi_tx_empty_enable = '1, spi_fault_irq_enable = '1, sci_tx_shift_empty = '0;
    logic sci_tx_data_empty = '0, sci_break_or_idle_gen = '0, sci_rx_read = '0;
    logic sci_rx_bit_tick = '0, sci_long_char = '0, sci_tx_empty_enable = '1, tx_done_enable = '1;
    logic sci_rx_full_enable = '1, line_quiet_enable = '1, rx_overrun_enable = '1;
    logic line_noise_enable = '1, stop_bit_bad_enable = '1, parity_bad_enable = '1;
    logic adc_request = '0, timebase_request = '0, software_trap_instr = '0, break_hit = '0;
    logic mask_set_by_sw = '0, mask_clear_by_sw = '0, instr_boundary, take_pulse, global_mask;
    logic [20:0] flag_clear = '0, flag_view;
    logic [15:0] pc_now = 16'h1234, stacked_pc;
    logic [16:1] pending_view;
    irq_mux_pkg::cpu_req_s cpu_req;
    int errors = 0, checks_done = 0, cycles = 0;
    // Flag bit and priority per stimulus index
    int fb[17] = '{2, 3, 4, 5, 6, 7, 8, 11, 18, 16, 15, 13, 14, 1, 0, 20, 19};
    int pr[17] = '{3, 4, 5, 6, 7, 8, 9, 10, 13, 12, 11, 11, 11, 2, 1, 14, 13};

    cpu_interrupt_source_mux dut (.*, .timer1({p[2:0], ten}), .timer2({p[5:3], ten}),
        .spi_rx_load(p[6]), .spi_tx_load(p[7]), .sci_tx_load(p[8]), .sci_rx_load(p[9]),
        .sci_parity_mismatch(p[10]), .sci_noise_seen(p[11]), .sci_stop_bit_zero(p[12]));
    cpu_seq_model seq (.clk(clk), .reset(reset), .slow(slow), .take_pulse(take_pulse),
        .instr_boundary(instr_boundary), .take_count(take_count));

    initial forever #2.5 clk = ~clk;

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (exp !== got) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic pulse(ref logic s);
        s = '1;
        tick(1);
        s = '0;
    endtask : pulse

    // Answer lasts one cycle, so it is polled right after each edge
    task automatic take(input logic [4:0] pri, input logic tr, input logic [15:0] sp);
        int n = 0;
        while (take_pulse !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk("take", 1, take_pulse);
        chk("trap", tr, cpu_req.is_trap);
        chk("prio", pri, cpu_req.prio);
        chk("vector", tr ? 16'hFFFC : 16'hFFFC - {10'h000, pri, 1'b0}, cpu_req.vector);
        chk("stack", sp, stacked_pc);
        chk("mask", 1, global_mask);
    endtask : take

    initial begin
        tick(3);
        reset = '0;
        chk("mask_rst", 1, global_mask);
        chk("flags_rst", 0, flag_view);
        pulse(software_trap_instr);
        take(5'h00, '1, 16'h1234);
        pc_now = 16'h2222;
        pulse(break_hit);
        take(5'h00, '1, 16'h2222);
        pc_now = 16'h1234;
        for (int k = 0; k < 17; k++) begin
            slow = k[0];
            if (k < 13) p[k] = '1;
            else if (k == 13) pll_lock = ~pll_lock;
            else if (k == 14) ext_request_pin = '0;
            else if (k == 15) kbd_pin[3] = '0;
            else {sci_tx_shift_empty, sci_tx_data_empty} = 2'h3;
            tick(1);
            t0 = take_count;
            p = '0;
            ext_request_pin = '1;
            kbd_pin = 8'hFF;
            {sci_tx_shift_empty, sci_tx_data_empty} = 2'h0;
            tick(3);
            chk("flag", 1, flag_view[fb[k]]);
            chk("pending", 1, pending_view[pr[k]]);
            chk("held", t0, take_count);
            pulse(mask_clear_by_sw);
            take(pr[k][4:0], '0, 16'h1233);
            flag_clear[fb[k]] = '1;
            tick(1);
            flag_clear = '0;
            tick(1);
            chk("cleared", 0, flag_view[fb[k]]);
        end
        // Two sources at once: the lower priority waits behind the mask
        p = 13'h0044;
        tick(1);
        p = '0;
        tick(3);
        pulse(mask_clear_by_sw);
        take(5'h05, '0, 16'h1233);
        flag_clear = 21'h000010;
        tick(1);
        flag_clear = '0;
        pulse(mask_clear_by_sw);
        take(5'h09, '0, 16'h1233);
        flag_clear = 21'h000300;
        {spi_rx_read, sci_rx_read} = 2'h3;
        tick(1);
        flag_clear = '0;
        {spi_rx_read, sci_rx_read} = 2'h0;
        // Second byte lands while the first is still unread
        p = 13'h0240;
        tick(1);
        p = '0;
        tick(1);
        chk("no_overflow", 0, flag_view[9]);
        p = 13'h0240;
        tick(1);
        p = '0;
        tick(2);
        chk("spi_overflow", 1, flag_view[9]);
        chk("sci_overrun", 1, flag_view[12]);
        spi_master_mode = '1;
        slave_select_input = '0;
        tick(4);
        chk("fault_master", 1, flag_view[10]);
        flag_clear[10] = '1;
        spi_master_mode = '0;
        spi_transfer_active = '1;
        tick(1);
        flag_clear = '0;
        tick(1);
        chk("fault_clear", 0, flag_view[10]);
        slave_select_input = '1;
        tick(4);
        chk("fault_slave", 1, flag_view[10]);
        spi_transfer_active = '0;
        sci_rx_bit_tick = '1;
        tick(9);
        sci_rx_bit_tick = '0;
        tick(2);
        chk("quiet_early", 0, flag_view[17]);
        sci_rx_bit_tick = '1;
        tick(1);
        sci_rx_bit_tick = '0;
        tick(2);
        chk("quiet", 1, flag_view[17]);
        flag_clear = 21'h031700;
        tick(1);
        flag_clear = '0;
        pll_sync_change_enable = '0;
        pll_lock = ~pll_lock;
        tick(4);
        chk("flag_off", 1, flag_view[1]);
        chk("pend_off", 0, pending_view[2]);
        t0 = take_count;
        pulse(mask_clear_by_sw);
        tick(8);
        chk("no_take", t0, take_count);
        chk("mask_open", 0, global_mask);
        {adc_request, timebase_request} = 2'h3;
        take(5'h0F, '0, 16'h1233);
        adc_request = '0;
        pulse(mask_clear_by_sw);
        take(5'h10, '0, 16'h1233);
        chk("vec_lowest", 16'hFFDC, cpu_req.vector);
        timebase_request = '0;
        complete_run();
    end
endmodule : cpu_interrupt_source_mux_tb_top
